// File: spi_serial_core.sv
// SPI serial timing core: clock formats, bit order, rate, select output.
`timescale 1ns/100ps
// Functional notes
// RL1 - Polarity inverts serial clock; phase picks one of two data timings.
// RL2 - Each transfer is eight bit times; phase set starts bit one at edge one.
// RL3 - Phase set: select falls half period early, rises after bit eight.
// RL4 - Phase set slave drives output on select low; first edge shifts bit out.
// RL5 - Phase set: sample on even edges, shift on odd edges after first.
// RL6 - Phase set: queued byte follows at once, select stays low.
// RL7 - Phase clear: select falls at bit one, rises half period after bit eight.
// RL8 - Phase clear slave presents first bit as soon as select goes low.
// RL9 - Phase clear: sample on odd edges, shift on even edges.
// RL10 - Phase clear: far master must raise select between bytes.
// RL11 - Bit-order setting picks MSB or LSB first in both phases.
// RL12 - Prescaler divides bus clock by field value plus one.
// RL13 - Rate field divides by two to the field plus one, 2 to 512.
// RL14 - Rate divider runs only for a master transfer in progress.
// RL15 - Automatic select needs master, select-output and fault-detect enables.
// RL16 - Multi-master fault detection off while automatic select is on.
// RL17 - Multi-master systems cannot detect conflicts with automatic select.
// RL18 - Master with fault input low goes slave, aborts, sets fault flag.
// RL19 - Deselected slave floats output, ignores clock, idles on select rise.
// RL20 - After eighth shift byte goes to receive buffer, receive-full set.
// RL21 - Idle master serial clock rests at the polarity level.
module spi_serial_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire spi_core_pkg::reg_req_t regReq,
    output logic [7:0] regRdata,
    // Serial pins, sampled through synchronisers
    input wire logic sclkIn,
    input wire logic mosiIn,
    input wire logic misoIn,
    input wire logic selIn,
    output spi_core_pkg::pin_drive_t pins
);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LEAD = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_TRAIL = 4'b1000
    } mst_state_t;

    logic [7:0] ctrlOne_r, ctrlOne_nxt, ctrlTwo_r, ctrlTwo_nxt, rate_r, rate_nxt;
    logic [7:0] txBuf_r, txBuf_nxt, rxBuf_r, rxBuf_nxt, shift_r, shift_nxt;
    logic txFull_r, txFull_nxt, rxFull_r, rxFull_nxt, fault_r, fault_nxt;
    logic faultSeen_r, faultSeen_nxt, sample_r, sample_nxt, sclk_r, sclk_nxt;
    logic selOut_r, selOut_nxt;
    logic [4:0] edges_r, edges_nxt;
    mst_state_t state_r, state_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [3:0] syncA_r, syncB_r, syncC_r;
    logic halfTick, isMaster, lsbFirst, phase, polarity, autoSel, faultIn;
    logic slvSel, sclkRise, sclkFall, slvEdge, cfgWrite;

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            syncA_r <= 4'hf;
            syncB_r <= 4'hf;
            syncC_r <= 4'hf;
        end else begin
            syncA_r <= {sclkIn, mosiIn, misoIn, selIn};
            syncB_r <= syncA_r;
            syncC_r <= syncB_r;
        end
    end

    function automatic logic [7:0] shiftIn(input logic [7:0] v, input logic b, input logic lsb);
        shiftIn = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shiftIn

    function automatic logic outBit(input logic [7:0] v, input logic lsb);
        outBit = lsb ? v[0] : v[7];
    endfunction : outBit

    assign isMaster = ctrlOne_r[spi_core_pkg::MASTER_POS];
    assign lsbFirst = ctrlOne_r[spi_core_pkg::LSB_FIRST_POS];
    assign phase = ctrlOne_r[spi_core_pkg::PHASE_POS];
    assign polarity = ctrlOne_r[spi_core_pkg::POLARITY_POS];
    assign autoSel = isMaster && ctrlOne_r[spi_core_pkg::SELECT_OE_POS]
        && ctrlTwo_r[spi_core_pkg::FAULT_EN_POS]; // RL15
    assign faultIn = isMaster && ctrlTwo_r[spi_core_pkg::FAULT_EN_POS]
        && !ctrlOne_r[spi_core_pkg::SELECT_OE_POS] && !syncB_r[0]; // RL16 RL18
    assign slvSel = !isMaster && !syncB_r[0] && ctrlOne_r[spi_core_pkg::ENABLE_POS];
    // Edge detection on the polarity-corrected slave clock.
    assign sclkRise = (syncB_r[3] ^ polarity) && !(syncC_r[3] ^ polarity); // RL1
    assign sclkFall = !(syncB_r[3] ^ polarity) && (syncC_r[3] ^ polarity);
    assign slvEdge = slvSel && (sclkRise || sclkFall); // RL19
    assign cfgWrite = regReq.wr && (regReq.addr == spi_core_pkg::CONTROL_ONE_ADDR
        || regReq.addr == spi_core_pkg::CONTROL_TWO_ADDR
        || regReq.addr == spi_core_pkg::RATE_ADDR);

    spi_rate_gen u_rate (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(isMaster && state_r != ST_IDLE), // RL14
        .prescale(rate_r[spi_core_pkg::PRESCALE_POS +: 3]),
        .rateSel(rate_r[spi_core_pkg::RATE_SEL_POS +: 4]),
        .halfTick(halfTick)
    );

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    always_comb begin
        logic edgeOdd;
        edgeOdd = 1'b0;
        ctrlOne_nxt = ctrlOne_r;
        ctrlTwo_nxt = ctrlTwo_r;
        rate_nxt = rate_r;
        txBuf_nxt = txBuf_r;
        txFull_nxt = txFull_r;
        rxBuf_nxt = rxBuf_r;
        rxFull_nxt = rxFull_r;
        fault_nxt = fault_r;
        faultSeen_nxt = faultSeen_r;
        shift_nxt = shift_r;
        sample_nxt = sample_r;
        sclk_nxt = sclk_r;
        selOut_nxt = selOut_r;
        edges_nxt = edges_r;
        state_nxt = state_r;
        rdata_nxt = 8'h00;
        // Register writes.
        if (regReq.wr) begin
            unique case (regReq.addr)
                spi_core_pkg::CONTROL_ONE_ADDR: begin
                    ctrlOne_nxt = regReq.wdata;
                    if (faultSeen_r) begin
                        fault_nxt = 1'b0;
                    end
                end
                spi_core_pkg::CONTROL_TWO_ADDR: ctrlTwo_nxt = regReq.wdata;
                spi_core_pkg::RATE_ADDR: rate_nxt = regReq.wdata & 8'h7f;
                spi_core_pkg::DATA_ADDR: begin
                    txBuf_nxt = regReq.wdata;
                    txFull_nxt = 1'b1;
                end
                default: ;
            endcase
        end
        // Register reads.
        if (regReq.rd) begin
            unique case (regReq.addr)
                spi_core_pkg::CONTROL_ONE_ADDR: rdata_nxt = ctrlOne_r;
                spi_core_pkg::CONTROL_TWO_ADDR: rdata_nxt = ctrlTwo_r;
                spi_core_pkg::RATE_ADDR: rdata_nxt = rate_r;
                spi_core_pkg::STATUS_ADDR: begin
                    rdata_nxt[spi_core_pkg::RX_FULL_POS] = rxFull_r;
                    rdata_nxt[spi_core_pkg::TX_EMPTY_POS] = !txFull_r;
                    rdata_nxt[spi_core_pkg::FAULT_FLAG_POS] = fault_r;
                    rdata_nxt[spi_core_pkg::BUSY_POS] = state_r != ST_IDLE;
                    faultSeen_nxt = fault_r;
                end
                spi_core_pkg::DATA_ADDR: begin
                    rdata_nxt = rxBuf_r;
                    rxFull_nxt = 1'b0;
                end
                default: ;
            endcase
        end
        if (isMaster) begin
            unique case (state_r)
                ST_IDLE: begin
                    sclk_nxt = polarity; // RL21
                    selOut_nxt = 1'b1;
                    if (txFull_r && ctrlOne_r[spi_core_pkg::ENABLE_POS] && !cfgWrite) begin
                        shift_nxt = txBuf_r;
                        txFull_nxt = regReq.wr && regReq.addr == spi_core_pkg::DATA_ADDR;
                        edges_nxt = 5'h00;
                        state_nxt = ST_LEAD;
                    end
                end
                ST_LEAD: if (halfTick) begin
                    selOut_nxt = 1'b0; // RL3 RL7
                    state_nxt = ST_SHIFT;
                end
                ST_SHIFT: if (halfTick) begin
                    edgeOdd = !edges_r[0];
                    edges_nxt = edges_r + 5'h01;
                    sclk_nxt = !sclk_r; // RL1
                    if (phase ? !edgeOdd : edgeOdd) begin // RL5 RL9
                        sample_nxt = syncB_r[1];
                    end else if (!(phase && edges_r == 5'h00)) begin // RL4
                        shift_nxt = shiftIn(shift_r, sample_r, lsbFirst); // RL11
                    end
                    if (edges_r == 5'h0f) begin // RL2
                        state_nxt = ST_TRAIL;
                    end
                end
                ST_TRAIL: if (halfTick) begin
                    // With phase set the last shift completes the byte; with phase clear it is already whole.
                    rxBuf_nxt = phase ? shiftIn(shift_r, sample_r, lsbFirst) : shift_r; // RL20
                    rxFull_nxt = 1'b1; // RL20
                    if (phase && txFull_r && !cfgWrite) begin // RL6
                        // The queued byte's first edge lands where the trail would end.
                        shift_nxt = txBuf_r;
                        txFull_nxt = regReq.wr && regReq.addr == spi_core_pkg::DATA_ADDR;
                        sclk_nxt = !sclk_r; // RL6
                        edges_nxt = 5'h01;
                        state_nxt = ST_SHIFT;
                    end else begin
                        selOut_nxt = 1'b1; // RL3 RL7
                        state_nxt = ST_IDLE;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
            // A configuration change aborts a master transfer.
            if (cfgWrite && state_r != ST_IDLE) begin
                state_nxt = ST_IDLE;
                selOut_nxt = 1'b1;
                sclk_nxt = polarity;
            end
            if (faultIn) begin // RL18
                ctrlOne_nxt[spi_core_pkg::MASTER_POS] = 1'b0;
                fault_nxt = 1'b1;
                state_nxt = ST_IDLE;
                selOut_nxt = 1'b1;
            end
        end else begin
            state_nxt = ST_IDLE;
            if (!slvSel) begin // RL19
                edges_nxt = 5'h00;
                if (!phase) begin
                    shift_nxt = txFull_r ? txBuf_r : shift_r;
                end
            end else if (slvEdge) begin
                edgeOdd = !edges_r[0];
                edges_nxt = edges_r + 5'h01;
                if (phase ? !edgeOdd : edgeOdd) begin // RL5 RL9
                    sample_nxt = syncB_r[2];
                end else if (phase && edges_r == 5'h00) begin // RL4
                    shift_nxt = txFull_r ? txBuf_r : shift_r;
                    txFull_nxt = 1'b0;
                end else begin
                    shift_nxt = shiftIn(shift_r, sample_r, lsbFirst); // RL11
                end
                if (edges_r == 5'h0f && !phase) begin // RL8
                    rxBuf_nxt = shiftIn(shift_r, sample_r, lsbFirst);
                    rxFull_nxt = 1'b1; // RL20
                    txFull_nxt = 1'b0;
                    edges_nxt = 5'h00;
                end else if (edges_r == 5'h0f) begin
                    rxBuf_nxt = shiftIn(shift_r, syncB_r[2], lsbFirst);
                    rxFull_nxt = 1'b1; // RL20
                    edges_nxt = 5'h00;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlOne_r <= spi_core_pkg::CONTROL_ONE_RESET;
            ctrlTwo_r <= spi_core_pkg::CONTROL_TWO_RESET;
            rate_r <= spi_core_pkg::RATE_RESET;
            txBuf_r <= 8'h00;
            rxBuf_r <= 8'h00;
            shift_r <= 8'h00;
            txFull_r <= 1'b0;
            rxFull_r <= 1'b0;
            fault_r <= 1'b0;
            faultSeen_r <= 1'b0;
            sample_r <= 1'b0;
            sclk_r <= 1'b0;
            selOut_r <= 1'b1;
            edges_r <= 5'h00;
            state_r <= ST_IDLE;
            rdata_r <= 8'h00;
        end else begin
            ctrlOne_r <= ctrlOne_nxt;
            ctrlTwo_r <= ctrlTwo_nxt;
            rate_r <= rate_nxt;
            txBuf_r <= txBuf_nxt;
            rxBuf_r <= rxBuf_nxt;
            shift_r <= shift_nxt;
            txFull_r <= txFull_nxt;
            rxFull_r <= rxFull_nxt;
            fault_r <= fault_nxt;
            faultSeen_r <= faultSeen_nxt;
            sample_r <= sample_nxt;
            sclk_r <= sclk_nxt;
            selOut_r <= selOut_nxt;
            edges_r <= edges_nxt;
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // --------------------------------------------------------------
    // Pin drive
    // --------------------------------------------------------------
    always_comb begin
        pins.sclkOut = sclk_r;
        pins.sclkOe = isMaster;
        pins.mosiOut = outBit(shift_r, lsbFirst); // RL11
        pins.mosiOe = isMaster;
        pins.misoOut = outBit(shift_r, lsbFirst); // RL8
        pins.misoOe = slvSel; // RL4 RL19
        pins.selOut = selOut_r;
        pins.selOe = autoSel; // RL15
    end

    assign regRdata = rdata_r;

endmodule : spi_serial_core

// File: spi_core_pkg.sv
// Package of constants and carrier types for the SPI serial timing core.
package spi_core_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] CONTROL_ONE_ADDR = 4'h0;
    localparam logic [3:0] CONTROL_TWO_ADDR = 4'h1;
    localparam logic [3:0] RATE_ADDR = 4'h2;
    localparam logic [3:0] STATUS_ADDR = 4'h3;
    localparam logic [3:0] DATA_ADDR = 4'h4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LSB_FIRST_POS = 0;
    localparam int SELECT_OE_POS = 1;
    localparam int PHASE_POS = 2;
    localparam int POLARITY_POS = 3;
    localparam int MASTER_POS = 4;
    localparam int ENABLE_POS = 6;
    localparam int FAULT_EN_POS = 4;
    localparam int RATE_SEL_POS = 0;
    localparam int PRESCALE_POS = 4;
    localparam int RX_FULL_POS = 7;
    localparam int FAULT_FLAG_POS = 4;
    localparam int TX_EMPTY_POS = 5;
    localparam int BUSY_POS = 0;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] CONTROL_ONE_RESET = 8'h04;
    localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_FRAME = 4'h8;
    localparam logic [3:0] RATE_SEL_MAX = 4'h8;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic sclkOut;
        logic sclkOe;
        logic mosiOut;
        logic mosiOe;
        logic misoOut;
        logic misoOe;
        logic selOut;
        logic selOe;
    } pin_drive_t;

endpackage : spi_core_pkg

// File: spi_rate_gen.sv
// Bit-rate generator: prescaler and power-of-two rate divider.
`timescale 1ns/100ps
module spi_rate_gen (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic run,
    input wire logic [2:0] prescale,
    input wire logic [3:0] rateSel,
    // Half bit period tick
    output logic halfTick
);

    logic [2:0] preCnt_r;
    logic [2:0] preCnt_nxt;
    logic [8:0] divCnt_r;
    logic [8:0] divCnt_nxt;
    logic [8:0] halfLimit;
    logic tick;

    // --------------------------------------------------------------
    // Divider counters
    // --------------------------------------------------------------
    always_comb begin
        // Half of 2^(min(rateSel,8)+1) prescaled clocks between toggles.
        halfLimit = (rateSel >= spi_core_pkg::RATE_SEL_MAX) ? 9'h100 : (9'h001 << rateSel);
        preCnt_nxt = preCnt_r;
        divCnt_nxt = divCnt_r;
        tick = 1'b0;
        if (!run) begin // RL14
            preCnt_nxt = 3'h0;
            divCnt_nxt = 9'h000;
        end else if (preCnt_r == prescale) begin // RL12
            preCnt_nxt = 3'h0;
            if (divCnt_r + 9'h001 >= halfLimit) begin // RL13
                divCnt_nxt = 9'h000;
                tick = 1'b1;
            end else begin
                divCnt_nxt = divCnt_r + 9'h001;
            end
        end else begin
            preCnt_nxt = preCnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            preCnt_r <= 3'h0;
            divCnt_r <= 9'h000;
        end else begin
            preCnt_r <= preCnt_nxt;
            divCnt_r <= divCnt_nxt;
        end
    end

    assign halfTick = tick;

endmodule : spi_rate_gen

// File: spi_slave_model.sv
// Behavioural model of an external SPI slave on the serial link.
`timescale 1ns/100ps
module spi_slave_model (
    // Serial link
    input wire logic sclk,
    input wire logic mosi,
    input wire logic selN,
    output logic miso,
    // Format and data
    input wire logic clockPhase,
    input wire logic lsbFirst,
    input wire logic [7:0] txByte,
    output logic [7:0] rxByte
);
    int cnt;
    int pos;
    int idx;
    function automatic logic txBit(input int i);
        return lsbFirst ? txByte[i] : txByte[7 - i];
    endfunction : txBit
    initial begin
        miso = 1'b0;
        rxByte = 8'h00;
        cnt = 0;
    end
    // A falling select starts a frame; only with clockPhase clear does select have to rise between frames.
    always @(negedge selN) begin
        cnt = 0;
        if (!clockPhase) begin
            miso = txBit(0);
        end
    end
    // A released line shows the inverse of its last level.
    always @(posedge selN) begin
        miso = ~miso;
    end
    always @(sclk) begin
        if (selN === 1'b0) begin
            cnt = cnt + 1;
            pos = (cnt - 1) % 16;
            idx = pos / 2 + (clockPhase ? 0 : 1);
            if (pos[0] == clockPhase) begin
                rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
            end else if (idx < 8) begin
                miso = txBit(idx);
            end
        end
    end
endmodule : spi_slave_model

// File: spi_serial_core_sva.sv
// Checker for the SPI serial timing core.
`timescale 1ns/100ps
module spi_serial_core_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire spi_core_pkg::reg_req_t regReq,
    input wire logic [7:0] regRdata,
    // Serial pins
    input wire logic sclkIn,
    input wire logic mosiIn,
    input wire logic misoIn,
    input wire logic selIn,
    input wire spi_core_pkg::pin_drive_t pins
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic polR;
    logic phaR;
    logic faultR;
    logic sclkPrev;
    logic [5:0] togCnt;
    // Shadows of the format bits and a count of clock toggles per select period.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            polR <= spi_core_pkg::CONTROL_ONE_RESET[spi_core_pkg::POLARITY_POS];
            phaR <= spi_core_pkg::CONTROL_ONE_RESET[spi_core_pkg::PHASE_POS];
            faultR <= 1'b0;
            sclkPrev <= 1'b0;
            togCnt <= 6'h00;
        end else begin
            if (regReq.wr && regReq.addr == spi_core_pkg::CONTROL_ONE_ADDR) begin
                polR <= regReq.wdata[spi_core_pkg::POLARITY_POS];
                phaR <= regReq.wdata[spi_core_pkg::PHASE_POS];
            end
            if (regReq.wr && regReq.addr == spi_core_pkg::CONTROL_TWO_ADDR) begin
                faultR <= regReq.wdata[spi_core_pkg::FAULT_EN_POS];
            end
            togCnt <= pins.selOut ? 6'h00 : togCnt + 6'(pins.sclkOut != sclkPrev);
            sclkPrev <= pins.sclkOut;
        end
    end
    property p_idle_level;
        pins.sclkOe && pins.selOe && pins.selOut && $stable(polR)
            && polR == $past(polR, 2) && polR == $past(polR, 3) |-> pins.sclkOut == polR;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("clock off idle level");
    property p_sel_lead;
        $fell(pins.selOut) && pins.selOe |-> pins.sclkOut == polR;
    endproperty
    a_sel_lead: assert property (p_sel_lead) else $error("select fell after clock");
    property p_sample_stable;
        pins.selOe && !pins.selOut && $changed(pins.sclkOut)
            && pins.sclkOut == !(polR ^ phaR) |-> $stable(pins.mosiOut);
    endproperty
    a_sample_stable: assert property (p_sample_stable) else $error("data moved on sample edge");
    property p_sel_enable;
        pins.selOe |-> pins.sclkOe && faultR;
    endproperty
    a_sel_enable: assert property (p_sel_enable) else $error("select output wrongly on");
    property p_no_fault_auto;
        pins.selOe && $fell(pins.selOut) |=> pins.sclkOe [*4];
    endproperty
    a_no_fault_auto: assert property (p_no_fault_auto) else $error("fault under auto select");
    property p_fault_abort;
        faultR && pins.sclkOe && !pins.selOe && $fell(selIn) |-> ##[1:6] !pins.sclkOe;
    endproperty
    a_fault_abort: assert property (p_fault_abort) else $error("fault left master on");
    property p_slave_float;
        selIn && $past(selIn) && $past(selIn, 2) && $past(selIn, 3) |-> !pins.misoOe;
    endproperty
    a_slave_float: assert property (p_slave_float) else $error("deselected slave drives");
    property p_eight_bits;
        $rose(pins.selOut) && pins.selOe && $past(pins.selOe)
            |-> togCnt != 6'h00 && togCnt[3:0] == 4'h0;
    endproperty
    a_eight_bits: assert property (p_eight_bits) else $error("frame not sixteen edges");
endmodule : spi_serial_core_sva
bind spi_serial_core spi_serial_core_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regReq(regReq), .regRdata(regRdata), .sclkIn(sclkIn), .mosiIn(mosiIn),
    .misoIn(misoIn), .selIn(selIn), .pins(pins));

// File: tb.sv
// Self-checking testbench for the SPI serial timing core.
`timescale 1ns/100ps
module tb;
    logic clk_sys;
    logic sys_rst;
    spi_core_pkg::reg_req_t regReq;
    logic [7:0] regRdata;
    spi_core_pkg::pin_drive_t pins;
    logic faultSel, modelMiso, mPha, mLsb, rdSeen, prevSel, prevSclk;
    logic [7:0] mTx, mRx, half, d;
    logic [2:0] p;
    logic [3:0] r;
    logic [15:0] eq[$];
    logic [15:0] n;
    int fail_count, total_checks, cyc, lastTog, selRises, k, w;
    wire logic selIn = pins.selOe ? pins.selOut : faultSel;
    wire logic sclkIn = pins.sclkOe ? pins.sclkOut : 1'b0;
    wire logic mosiIn = pins.mosiOe ? pins.mosiOut : 1'b1;
    wire logic modelSel = pins.selOe ? pins.selOut : 1'b1;
    spi_serial_core u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regReq(regReq),
        .regRdata(regRdata), .sclkIn(sclkIn), .mosiIn(mosiIn), .misoIn(modelMiso),
        .selIn(selIn), .pins(pins));
    spi_slave_model u_model (.sclk(pins.sclkOut), .mosi(pins.mosiOut), .selN(modelSel),
        .miso(modelMiso), .clockPhase(mPha), .lsbFirst(mLsb), .txByte(mTx), .rxByte(mRx));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] dat);
        regReq <= '{addr: a, wdata: dat, wr: wr, rd: !wr};
        @(posedge clk_sys);
        regReq <= '0;
        @(posedge clk_sys);
    endtask : bus
    task automatic rdx(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        eq.push_back({e & m, m});
        bus(1'b0, a, 8'h00);
    endtask : rdx
    task automatic waitFull;
        for (k = 0; k < 300; k++) begin
            rdx(spi_core_pkg::STATUS_ADDR, 8'h00, 8'h00);
            if (regRdata[spi_core_pkg::RX_FULL_POS] === 1'b1) break;
        end
    endtask : waitFull
    // ------------------------------------------------------------------
    // Read results and link timing
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rdSeen) begin
            n = eq.pop_front();
            check("rdata", regRdata & n[7:0], n[15:8]);
        end
        rdSeen = regReq.rd;
        if (pins.selOe === 1'b1 && pins.selOut !== prevSel) begin
            if (pins.selOut === 1'b1) begin
                selRises++;
                check("selTrail", 8'(cyc - lastTog), half);
            end else begin
                lastTog = cyc;
            end
        end else if (pins.selOe === 1'b1 && pins.selOut === 1'b0 && pins.sclkOut !== prevSclk) begin
            check("halfBit", 8'(cyc - lastTog), half);
            lastTog = cyc;
        end
        prevSel = pins.selOut;
        prevSclk = pins.sclkOut;
        cyc++;
        if (cyc > 40000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        regReq = '0;
        faultSel = 1'b1;
        sys_rst = 1'b1;
        rdSeen = 1'b0;
        prevSel = 1'b1;
        prevSclk = 1'b0;
        {mPha, mLsb, mTx, half} = '0;
        w = $urandom(32'h9d70d2aa);
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        check("sclkReset", 8'(pins.sclkOut), 8'h00);
        check("selReset", 8'(pins.selOut), 8'h01);
        rdx(spi_core_pkg::CONTROL_ONE_ADDR, spi_core_pkg::CONTROL_ONE_RESET, 8'hff);
        rdx(spi_core_pkg::CONTROL_TWO_ADDR, spi_core_pkg::CONTROL_TWO_RESET, 8'hff);
        rdx(spi_core_pkg::RATE_ADDR, spi_core_pkg::RATE_RESET, 8'hff);
        bus(1'b1, 4'hf, 8'h5a);
        rdx(4'hf, 8'h00, 8'hff);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            mLsb = i[0];
            mPha = i[1];
            p = (i == 7) ? 3'h7 : (i == 0) ? 3'h3 : 3'($urandom % 2);
            r = (i == 0) ? 4'h0 : (i == 7) ? 4'h1 : 4'(2 + $urandom % 2);
            half = 8'((p + 1) << r);
            bus(1'b1, spi_core_pkg::RATE_ADDR, {1'b0, p, r});
            bus(1'b1, spi_core_pkg::CONTROL_TWO_ADDR, 8'h10);
            bus(1'b1, spi_core_pkg::CONTROL_ONE_ADDR, {4'h5, i[2], i[1], 1'b1, i[0]});
            mTx = 8'($urandom);
            d = 8'($urandom);
            bus(1'b1, spi_core_pkg::DATA_ADDR, d);
            waitFull();
            rdx(spi_core_pkg::DATA_ADDR, mTx, 8'hff);
            check("slaveRx", mRx, d);
            rdx(spi_core_pkg::STATUS_ADDR, 8'h00, 8'h80);
            $display("test mode %0d done", i);
        end
        rdx(spi_core_pkg::STATUS_ADDR, 8'h00, 8'h10);
        k = selRises;
        bus(1'b1, spi_core_pkg::DATA_ADDR, d);
        d = 8'($urandom);
        bus(1'b1, spi_core_pkg::DATA_ADDR, d);
        for (w = 0; w < 800 && selRises == k; w++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        check("selRises", 8'(selRises - k), 8'h01);
        check("slaveRx2", mRx, d);
        rdx(spi_core_pkg::DATA_ADDR, mTx, 8'hff);
        $display("test back to back done");
        bus(1'b1, spi_core_pkg::CONTROL_ONE_ADDR, 8'h54);
        bus(1'b1, spi_core_pkg::DATA_ADDR, d);
        repeat (4) @(posedge clk_sys);
        faultSel <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rdx(spi_core_pkg::STATUS_ADDR, 8'h10, 8'h10);
        faultSel <= 1'b1;
        rdx(spi_core_pkg::CONTROL_ONE_ADDR, 8'h00, 8'h10);
        bus(1'b1, spi_core_pkg::CONTROL_ONE_ADDR, 8'h54);
        rdx(spi_core_pkg::STATUS_ADDR, 8'h00, 8'h10);
        $display("test fault done");
        end_sim();
    end
endmodule : tb
